// >>> core/modcfg_pkg.sv
// Constants and types for the modulator configuration command decoder
// Notes on behaviour
// - Opcode 2601h loads full modulator configuration
// - Frequency, three zero bytes, later auxiliary clock
// - Data rate follows reserved, precedes auxiliary clock
// - Modulation: 0 QPSK,1 BPSK,2 8PSK,4 OQPSK
// - Accepting command forces transmit carrier off
// - Encoder codes: none, Viterbi, sequential, trellis
// - RS enable then codeword N, message K
// - T byte zero; derive T from N,K
// - Interleaver depth only 4 or 8
// - Scrambler, differential enables; scrambler type codes
// - Power signed tenths dBm, -50 to -300
// - Carrier control codes 0 to 5
// - Carrier selection: normal, CW, dual, offset
// - Spectrum normal on 0, inverted 1
// - Mode 1 sends 2047-bit test pattern
// - Clock control: internal send or terminal timing
// - Clock polarity normal, inverted, automatic
// - Send clock source: oscillator, recovered, coaxial
// - Alarm mask bit 0 masks, 1 allows
// - Major mask bit order fixed
// - Minor mask bit order fixed
// - Common mask bits 0 to 5 order
package modcfg_pkg;

  // Command opcode and payload length
  localparam logic [15:0] OPCODE_MOD_CONFIG = 16'h2601;
  localparam logic [5:0]  PAYLOAD_BYTES     = 6'h25;

  // Byte offsets inside the payload
  localparam logic [5:0] OFS_FREQ      = 6'h00;
  localparam logic [5:0] OFS_RSVD      = 6'h04;
  localparam logic [5:0] OFS_RATE      = 6'h07;
  localparam logic [5:0] OFS_AUXCLK    = 6'h0b;
  localparam logic [5:0] OFS_MODTYPE   = 6'h0f;
  localparam logic [5:0] OFS_ENCODER   = 6'h10;
  localparam logic [5:0] OFS_RS_EN     = 6'h11;
  localparam logic [5:0] OFS_RS_N      = 6'h12;
  localparam logic [5:0] OFS_RS_K      = 6'h13;
  localparam logic [5:0] OFS_RS_T      = 6'h14;
  localparam logic [5:0] OFS_RS_DEPTH  = 6'h15;
  localparam logic [5:0] OFS_SCR_EN    = 6'h16;
  localparam logic [5:0] OFS_SCR_TYPE  = 6'h17;
  localparam logic [5:0] OFS_POWER     = 6'h18;
  localparam logic [5:0] OFS_DIFF_EN   = 6'h1a;
  localparam logic [5:0] OFS_CARR_CTL  = 6'h1b;
  localparam logic [5:0] OFS_CARR_SEL  = 6'h1c;
  localparam logic [5:0] OFS_SPECTRUM  = 6'h1d;
  localparam logic [5:0] OFS_OPMODE    = 6'h1e;
  localparam logic [5:0] OFS_CLK_CTL   = 6'h1f;
  localparam logic [5:0] OFS_CLK_POL   = 6'h20;
  localparam logic [5:0] OFS_SCLK_SRC  = 6'h21;
  localparam logic [5:0] OFS_MASK_MAJ  = 6'h22;
  localparam logic [5:0] OFS_MASK_MIN  = 6'h23;
  localparam logic [5:0] OFS_MASK_COM  = 6'h24;
  localparam logic [5:0] LAST_BYTE     = 6'h24;

  // Field codes
  localparam logic [7:0] MOD_QPSK   = 8'h00;
  localparam logic [7:0] MOD_BPSK   = 8'h01;
  localparam logic [7:0] MOD_8PSK   = 8'h02;
  localparam logic [7:0] MOD_OQPSK  = 8'h04;
  localparam logic [7:0] CARRIER_OFF = 8'h00;
  localparam logic [7:0] CARRIER_MAX = 8'h05;
  localparam logic [7:0] CARR_SEL_MAX = 8'h03;
  localparam logic [7:0] DEPTH_A    = 8'h04;
  localparam logic [7:0] DEPTH_B    = 8'h08;
  localparam logic [15:0] POWER_HI  = 16'hffce;
  localparam logic [15:0] POWER_LO  = 16'hfed4;
  localparam logic [7:0] COMMON_MASK_BITS = 8'h3f;

  // APB register byte addresses
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_STATUS  = 8'h04;
  localparam logic [7:0] ADDR_OPCODE  = 8'h08;
  localparam logic [7:0] ADDR_DATA    = 8'h0c;
  localparam logic [7:0] ADDR_FREQ    = 8'h10;
  localparam logic [7:0] ADDR_RATE    = 8'h14;
  localparam logic [7:0] ADDR_AUXCLK  = 8'h18;
  localparam logic [7:0] ADDR_FEC     = 8'h1c;
  localparam logic [7:0] ADDR_TX      = 8'h20;
  localparam logic [7:0] ADDR_MASK    = 8'h24;
  localparam logic [7:0] ADDR_COUNT   = 8'h28;

  // Decoder states
  typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_APPLY} dec_state_type;

endpackage

// >>> core/modcfg_rs_t.sv
// Reed-Solomon correction capability derived from N and K
module modcfg_rs_t
  import modcfg_pkg::*;
(
  // Codeword parameters
  input  wire logic [7:0] RS_N_IN,
  input  wire logic [7:0] RS_K_IN,
  // Derived capability
  output logic      [7:0] RS_T_OUT
);
  logic [7:0] diff;

  // T is half the parity count; K above N yields zero
  always_comb begin
    diff = (RS_N_IN > RS_K_IN) ? 8'(RS_N_IN - RS_K_IN) : 8'h00;
    RS_T_OUT = {1'b0, diff[7:1]};
  end
endmodule

// >>> core/modcfg_field_check.sv
// Range checks of the decoded configuration fields
module modcfg_field_check
  import modcfg_pkg::*;
(
  // Fields under test
  input  wire logic [7:0]  MODTYPE_IN,
  input  wire logic [7:0]  ENCODER_IN,
  input  wire logic [7:0]  DEPTH_IN,
  input  wire logic [7:0]  SCR_TYPE_IN,
  input  wire logic [15:0] POWER_IN,
  input  wire logic [7:0]  CARR_CTL_IN,
  input  wire logic [7:0]  CARR_SEL_IN,
  // One when every field is legal
  output logic             FIELDS_OK_OUT
);
  logic mod_ok;
  logic enc_ok;
  logic dep_ok;
  logic scr_ok;
  logic pwr_ok;

  // Legal code sets of each field
  always_comb begin
    mod_ok = (MODTYPE_IN == MOD_QPSK) || (MODTYPE_IN == MOD_BPSK) ||
             (MODTYPE_IN == MOD_8PSK) || (MODTYPE_IN == MOD_OQPSK);
    enc_ok = (ENCODER_IN == 8'h00) || (ENCODER_IN == 8'h0e) ||
             ((ENCODER_IN <= 8'h0b) && ENCODER_IN[0]);
    dep_ok = (DEPTH_IN == DEPTH_A) || (DEPTH_IN == DEPTH_B);
    scr_ok = (SCR_TYPE_IN <= 8'h04) || (SCR_TYPE_IN == 8'h07) || (SCR_TYPE_IN == 8'h08);
    pwr_ok = ($signed(POWER_IN) <= $signed(POWER_HI)) && ($signed(POWER_IN) >= $signed(POWER_LO));
    FIELDS_OK_OUT = mod_ok && enc_ok && dep_ok && scr_ok && pwr_ok &&
                    (CARR_CTL_IN <= CARRIER_MAX) && (CARR_SEL_IN <= CARR_SEL_MAX);
  end
endmodule

// >>> core/modcfg_decoder.sv
// Modulator configuration command decoder with APB access
module modcfg_decoder
  import modcfg_pkg::*;
(
  // Clock and reset
  input  wire logic        CLOCK_IN,
  input  wire logic        RESETN_IN,
  // APB slave
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [7:0]  PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  output logic      [31:0] PRDATA_OUT,
  output logic             PREADY_OUT,
  output logic             PSLVERR_OUT,
  // Applied transmit configuration
  output logic      [31:0] CARRIER_FREQ_OUT,
  output logic      [31:0] DATA_RATE_OUT,
  output logic      [31:0] AUXILIARY_CLOCK_FREQUENCY_OUT,
  output logic      [7:0]  MOD_TYPE_OUT,
  output logic      [7:0]  ENCODER_OUT,
  output logic             RS_ENABLE_OUT,
  output logic      [7:0]  RS_N_OUT,
  output logic      [7:0]  RS_K_OUT,
  output logic      [7:0]  RS_T_OUT,
  output logic      [7:0]  RS_DEPTH_OUT,
  output logic             SCRAMBLER_EN_OUT,
  output logic      [7:0]  SCRAMBLER_TYPE_OUT,
  output logic      [15:0] TX_POWER_OUT,
  output logic             DIFF_ENCODER_EN_OUT,
  output logic      [7:0]  CARRIER_CTRL_OUT,
  output logic      [7:0]  CARRIER_SELECT_OUT,
  output logic             SPECTRUM_INVERT_OUT,
  output logic             TEST_PATTERN_OUT,
  output logic             USE_TERMINAL_TIMING_CLOCK_OUT,
  output logic      [1:0]  CLOCK_POLARITY_OUT,
  output logic      [1:0]  INTERNAL_SEND_CLOCK_SRC_OUT,
  output logic      [7:0]  MAJOR_MASK_OUT,
  output logic      [7:0]  MINOR_MASK_OUT,
  output logic      [7:0]  COMMON_MASK_OUT,
  // Applied strobe
  output logic             CONFIG_APPLIED_OUT
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    dec_state_type state;
    logic [5:0]    idx;
    logic [7:0]    shadow_mod;
    logic [7:0]    shadow_enc;
    logic [7:0]    shadow_depth;
    logic [7:0]    shadow_scr;
    logic [15:0]   shadow_pwr;
    logic [7:0]    shadow_cctl;
    logic [7:0]    shadow_csel;
    logic [295:0]  pay;
    logic [295:0]  cfg;
    logic [7:0]    rs_t;
    logic          applied;
    logic          bad_opcode;
    logic          bad_field;
    logic [15:0]   count;
    logic [31:0]   rdata;
  } state_type;

  state_type q;
  state_type d;

  logic        fields_ok;
  logic [7:0]  t_calc;
  logic        setup;
  logic        access;
  logic [7:0]  b;

  // Pick a byte out of the collected payload
  function automatic logic [7:0] pb(input logic [295:0] p, input logic [5:0] o);
    pb = p[9'(o) * 9'd8 +: 8];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  modcfg_field_check u_check (
    .MODTYPE_IN    (pb(q.pay, OFS_MODTYPE)),
    .ENCODER_IN    (pb(q.pay, OFS_ENCODER)),
    .DEPTH_IN      (pb(q.pay, OFS_RS_DEPTH)),
    .SCR_TYPE_IN   (pb(q.pay, OFS_SCR_TYPE)),
    .POWER_IN      ({pb(q.pay, OFS_POWER), pb(q.pay, 6'(OFS_POWER + 6'h01))}),
    .CARR_CTL_IN   (pb(q.pay, OFS_CARR_CTL)),
    .CARR_SEL_IN   (pb(q.pay, OFS_CARR_SEL)),
    .FIELDS_OK_OUT (fields_ok)
  );

  // derive T from N and K
  modcfg_rs_t u_rs_t (
    .RS_N_IN  (pb(q.pay, OFS_RS_N)),
    .RS_K_IN  (pb(q.pay, OFS_RS_K)),
    .RS_T_OUT (t_calc)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  assign setup  = PSEL_IN && !PENABLE_IN;
  assign access = PSEL_IN && PENABLE_IN;
  assign b      = PWDATA_IN[7:0];

  // Bus decode, payload collection and apply sequence
  always_comb begin
    d = q;
    d.applied = 1'b0;
    unique case (q.state)
      ST_IDLE: begin
        if (access && PWRITE_IN && PADDR_IN == ADDR_OPCODE) begin
          if (PWDATA_IN[15:0] == OPCODE_MOD_CONFIG) begin
            d.state      = ST_LOAD;
            d.idx        = 6'h00;
            d.bad_opcode = 1'b0;
          end else begin
            d.bad_opcode = 1'b1;
          end
        end
      end
      ST_LOAD: begin
        // bytes land at their payload offsets, big endian
        // data rate between reserved bytes and auxiliary clock
        if (access && PWRITE_IN && PADDR_IN == ADDR_DATA) begin
          d.pay[9'(q.idx) * 9'd8 +: 8] = b;
          if (q.idx == LAST_BYTE) begin
            d.state = ST_APPLY;
          end else begin
            d.idx = 6'(q.idx + 6'h01);
          end
        end
        // Abort by control write drops the partial payload
        if (access && PWRITE_IN && PADDR_IN == ADDR_CTRL && PWDATA_IN[0]) begin
          d.state = ST_IDLE;
        end
      end
      ST_APPLY: begin
        // every field copied together once payload complete and fields_ok
        if (fields_ok) begin
          d.cfg       = q.pay;
          d.rs_t      = t_calc;
          d.applied   = 1'b1;
          d.bad_field = 1'b0;
          d.count     = 16'(q.count + 16'h0001);
        end else begin
          d.bad_field = 1'b1;
        end
        d.state = ST_IDLE;
      end
    endcase
    // Sticky error flags cleared by control bit 1; a new error wins
    if (access && PWRITE_IN && PADDR_IN == ADDR_CTRL && PWDATA_IN[1] &&
        !(q.state == ST_APPLY && !fields_ok)) begin
      d.bad_field = 1'b0;
      if (!(q.state == ST_IDLE && PADDR_IN == ADDR_OPCODE)) begin
        d.bad_opcode = 1'b0;
      end
    end
    // Read data latched in setup so it comes from a flop
    if (setup && !PWRITE_IN) begin
      unique case (PADDR_IN)
        ADDR_CTRL:   d.rdata = 32'h0000_0000;
        ADDR_STATUS: d.rdata = {26'h0, q.bad_field, q.bad_opcode, q.idx == 6'h00, 1'b0,
                                q.state == ST_LOAD, q.state == ST_APPLY};
        ADDR_OPCODE: d.rdata = {16'h0000, OPCODE_MOD_CONFIG};
        ADDR_DATA:   d.rdata = {26'h0, q.idx};
        ADDR_FREQ:   d.rdata = CARRIER_FREQ_OUT;
        ADDR_RATE:   d.rdata = DATA_RATE_OUT;
        ADDR_AUXCLK: d.rdata = AUXILIARY_CLOCK_FREQUENCY_OUT;
        ADDR_FEC:    d.rdata = {ENCODER_OUT, RS_N_OUT, RS_K_OUT, RS_T_OUT};
        ADDR_TX:     d.rdata = {TX_POWER_OUT, CARRIER_CTRL_OUT, MOD_TYPE_OUT};
        ADDR_MASK:   d.rdata = {8'h00, COMMON_MASK_OUT, MINOR_MASK_OUT, MAJOR_MASK_OUT};
        ADDR_COUNT:  d.rdata = {16'h0000, q.count};
        default:     d.rdata = 32'h0000_0000;
      endcase
    end
  end

  // State register
  always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Zero-wait APB; unmapped address errors
  assign PREADY_OUT  = 1'b1;
  assign PSLVERR_OUT = access && (PADDR_IN > ADDR_COUNT || PADDR_IN[1:0] != 2'b00);
  assign PRDATA_OUT  = q.rdata;
  assign CONFIG_APPLIED_OUT = q.applied;

  // Field outputs straight from the applied copy, except T (q.rs_t) and carrier control
  assign CARRIER_FREQ_OUT = {pb(q.cfg, 6'h00), pb(q.cfg, 6'h01), pb(q.cfg, 6'h02), pb(q.cfg, 6'h03)};
  assign DATA_RATE_OUT    = {pb(q.cfg, 6'h07), pb(q.cfg, 6'h08), pb(q.cfg, 6'h09), pb(q.cfg, 6'h0a)};
  assign AUXILIARY_CLOCK_FREQUENCY_OUT =
    {pb(q.cfg, 6'h0b), pb(q.cfg, 6'h0c), pb(q.cfg, 6'h0d), pb(q.cfg, 6'h0e)};
  assign MOD_TYPE_OUT     = pb(q.cfg, OFS_MODTYPE);
  assign ENCODER_OUT      = pb(q.cfg, OFS_ENCODER);
  assign RS_ENABLE_OUT    = pb(q.cfg, OFS_RS_EN) == 8'h01;
  assign RS_N_OUT         = pb(q.cfg, OFS_RS_N);
  assign RS_K_OUT         = pb(q.cfg, OFS_RS_K);
  assign RS_T_OUT         = q.rs_t;
  assign RS_DEPTH_OUT     = pb(q.cfg, OFS_RS_DEPTH);
  assign SCRAMBLER_EN_OUT    = pb(q.cfg, OFS_SCR_EN) == 8'h01;
  assign SCRAMBLER_TYPE_OUT  = pb(q.cfg, OFS_SCR_TYPE);
  assign TX_POWER_OUT        = {pb(q.cfg, OFS_POWER), pb(q.cfg, 6'(OFS_POWER + 6'h01))};
  assign DIFF_ENCODER_EN_OUT = pb(q.cfg, OFS_DIFF_EN) == 8'h01;
  // command forces carrier off whatever the byte held
  assign CARRIER_CTRL_OUT    = CARRIER_OFF;
  assign CARRIER_SELECT_OUT  = pb(q.cfg, OFS_CARR_SEL);
  assign SPECTRUM_INVERT_OUT = pb(q.cfg, OFS_SPECTRUM) == 8'h01;
  assign TEST_PATTERN_OUT    = pb(q.cfg, OFS_OPMODE) == 8'h01;
  assign USE_TERMINAL_TIMING_CLOCK_OUT = pb(q.cfg, OFS_CLK_CTL) == 8'h01;
  assign CLOCK_POLARITY_OUT  = 2'(pb(q.cfg, OFS_CLK_POL));
  assign INTERNAL_SEND_CLOCK_SRC_OUT = 2'(pb(q.cfg, OFS_SCLK_SRC));
  // mask bits in order, 1 allows
  assign MAJOR_MASK_OUT  = pb(q.cfg, OFS_MASK_MAJ);
  assign MINOR_MASK_OUT  = pb(q.cfg, OFS_MASK_MIN);
  assign COMMON_MASK_OUT = pb(q.cfg, OFS_MASK_COM) & COMMON_MASK_BITS;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  property p_apply_after_full;
    @(posedge CLOCK_IN) disable iff (!RESETN_IN)
      $rose(q.applied) |-> $past(q.state) == ST_APPLY;
  endproperty
  a_apply_after_full: assert property (p_apply_after_full) else $error("apply without full payload");

  property p_carrier_off;
    @(posedge CLOCK_IN) disable iff (!RESETN_IN)
      q.applied |-> CARRIER_CTRL_OUT == CARRIER_OFF;
  endproperty
  a_carrier_off: assert property (p_carrier_off) else $error("carrier not off");

  property p_opcode_start;
    @(posedge CLOCK_IN) disable iff (!RESETN_IN)
      (q.state == ST_IDLE && access && PWRITE_IN && PADDR_IN == ADDR_OPCODE &&
       PWDATA_IN[15:0] == OPCODE_MOD_CONFIG) |=> q.state == ST_LOAD && q.idx == 6'h00;
  endproperty
  a_opcode_start: assert property (p_opcode_start) else $error("opcode not accepted");

  property p_depth;
    @(posedge CLOCK_IN) disable iff (!RESETN_IN)
      q.applied |-> RS_DEPTH_OUT == DEPTH_A || RS_DEPTH_OUT == DEPTH_B;
  endproperty
  a_depth: assert property (p_depth) else $error("bad depth applied");

  property p_rs_t;
    @(posedge CLOCK_IN) disable iff (!RESETN_IN)
      q.applied && RS_N_OUT >= RS_K_OUT |-> RS_T_OUT == 8'((RS_N_OUT - RS_K_OUT) >> 1);
  endproperty
  a_rs_t: assert property (p_rs_t) else $error("wrong T");

  property p_power;
    @(posedge CLOCK_IN) disable iff (!RESETN_IN)
      q.applied |-> $signed(TX_POWER_OUT) <= -16'sd50 && $signed(TX_POWER_OUT) >= -16'sd300;
  endproperty
  a_power: assert property (p_power) else $error("power out of range");

  property p_modtype;
    @(posedge CLOCK_IN) disable iff (!RESETN_IN)
      q.applied |-> MOD_TYPE_OUT inside {8'h00, 8'h01, 8'h02, 8'h04};
  endproperty
  a_modtype: assert property (p_modtype) else $error("bad modulation");

  property p_cfg_stable;
    @(posedge CLOCK_IN) disable iff (!RESETN_IN)
      !q.applied |-> $stable(q.cfg);
  endproperty
  a_cfg_stable: assert property (p_cfg_stable) else $error("partial config applied");

  property p_common_mask;
    @(posedge CLOCK_IN) disable iff (!RESETN_IN)
      COMMON_MASK_OUT[7:6] == 2'b00;
  endproperty
  a_common_mask: assert property (p_common_mask) else $error("spare common mask bits set");

  property p_load_done;
    @(posedge CLOCK_IN) disable iff (!RESETN_IN)
      (q.state == ST_LOAD && q.idx == LAST_BYTE && access && PWRITE_IN && PADDR_IN == ADDR_DATA)
        |=> q.state == ST_APPLY ##1 q.state == ST_IDLE;
  endproperty
  a_load_done: assert property (p_load_done) else $error("apply step missed");

endmodule

// >>> tb/cfg_host_model.sv
// Host-side model: APB master that delivers configuration commands
module cfg_host_model
  import modcfg_pkg::*;
(
  // Clock
  input  wire logic        clock_in,
  // APB master side
  output logic             psel_out,
  output logic             penable_out,
  output logic             pwrite_out,
  output logic      [7:0]  paddr_out,
  output logic      [31:0] pwdata_out,
  input  wire logic [31:0] prdata_in,
  input  wire logic        pready_in,
  input  wire logic        pslverr_in
);
  timeunit 1ns;
  timeprecision 1ps;

  ////////////////////////////////////////
  // Idle bus at time zero
  initial begin
    psel_out    = 1'b0;
    penable_out = 1'b0;
    pwrite_out  = 1'b0;
    paddr_out   = 8'h00;
    pwdata_out  = 32'h0;
  end

  // One transfer; released lines show inverted values so stale data never passes
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge clock_in);
    psel_out    <= 1'b1;
    penable_out <= 1'b0;
    pwrite_out  <= w;
    paddr_out   <= a;
    pwdata_out  <= d;
    @(posedge clock_in);
    penable_out <= 1'b1;
    // Wait for the answer; only the bench watchdog ends a hang
    do begin
      @(posedge clock_in);
    end while (pready_in !== 1'b1);
    rd = prdata_in;
    err = pslverr_in;
    psel_out    <= 1'b0;
    penable_out <= 1'b0;
    paddr_out   <= ~a;
    pwdata_out  <= ~d;
  endtask

  task automatic send_opcode(input logic [15:0] op);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, ADDR_OPCODE, {16'h0, op}, rd, err);
  endtask
endmodule

// >>> tb/tb_top.sv
// Self-checking bench for the modulator configuration decoder
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin miscompares++; \
  $display("mismatch at %0t got %0h expected %0h", $time, (got), (exp)); end end
module tb_top
  import modcfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0;
  logic resetn_n;
  logic psel, pen, pwr, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic er;
  logic [31:0] freq_w, rate_w, aux_w;
  logic [7:0]  mod_w, enc_w, n_w, k_w, t_w, dep_w, scrt_w, cctl_w, csel_w, maj_w, min_w, com_w, last_mod;
  logic        rsen_w, scren_w, diff_w, spec_w, test_w, term_w, applied_w;
  logic [15:0] pwr_w;
  logic [1:0]  pol_w, src_w;
  logic [7:0]  pl [37];
  logic [7:0]  mod_t  [8] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h00, 8'h01, 8'h02, 8'h04};
  logic [7:0]  enc_t  [8] = '{8'h00, 8'h01, 8'h03, 8'h05, 8'h07, 8'h09, 8'h0b, 8'h0e};
  logic [7:0]  scr_t  [8] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h07, 8'h08, 8'h00};
  logic [7:0]  cctl_t [8] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h01, 8'h02};
  int miscompares, checks_done;
  int pulses = 0;

  ////////////////////////////////////////
  // 50 MHz clock
  always #10 clk = ~clk;

  // Count applied strobes
  always @(posedge clk) if (applied_w === 1'b1) pulses <= pulses + 1;

  cfg_host_model host_inst (.clock_in(clk), .psel_out(psel), .penable_out(pen), .pwrite_out(pwr),
    .paddr_out(paddr), .pwdata_out(pwdata), .prdata_in(prdata), .pready_in(pready), .pslverr_in(pslverr));

  modcfg_decoder modcfg_decoder_inst (.CLOCK_IN(clk), .RESETN_IN(resetn_n), .PSEL_IN(psel),
    .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .CARRIER_FREQ_OUT(freq_w), .DATA_RATE_OUT(rate_w),
    .AUXILIARY_CLOCK_FREQUENCY_OUT(aux_w), .MOD_TYPE_OUT(mod_w), .ENCODER_OUT(enc_w),
    .RS_ENABLE_OUT(rsen_w), .RS_N_OUT(n_w), .RS_K_OUT(k_w), .RS_T_OUT(t_w), .RS_DEPTH_OUT(dep_w),
    .SCRAMBLER_EN_OUT(scren_w), .SCRAMBLER_TYPE_OUT(scrt_w), .TX_POWER_OUT(pwr_w),
    .DIFF_ENCODER_EN_OUT(diff_w), .CARRIER_CTRL_OUT(cctl_w), .CARRIER_SELECT_OUT(csel_w),
    .SPECTRUM_INVERT_OUT(spec_w), .TEST_PATTERN_OUT(test_w), .USE_TERMINAL_TIMING_CLOCK_OUT(term_w),
    .CLOCK_POLARITY_OUT(pol_w), .INTERNAL_SEND_CLOCK_SRC_OUT(src_w), .MAJOR_MASK_OUT(maj_w),
    .MINOR_MASK_OUT(min_w), .COMMON_MASK_OUT(com_w), .CONFIG_APPLIED_OUT(applied_w));

  ////////////////////////////////////////
  // Payload number i; every field except the N byte and the reserved bytes takes a code chosen by i
  task automatic build(input int i);
    {pl[0], pl[1], pl[2], pl[3]} = 32'h3b9a_ca00 + i;
    {pl[4], pl[5], pl[6]} = 24'h0;
    {pl[7], pl[8], pl[9], pl[10]} = 32'h0001_f400 + (i << 12);
    {pl[11], pl[12], pl[13], pl[14]} = 32'h00c3_5000 + (i << 4);
    pl[15] = mod_t[i];
    pl[16] = enc_t[i];
    pl[17] = {7'h0, i[0]};
    pl[18] = 8'hcc;
    pl[19] = 8'(188 - 2 * i);
    // last payload breaks the zero T byte on purpose
    pl[20] = (i == 7) ? 8'h55 : 8'h00;
    pl[21] = i[0] ? DEPTH_B : DEPTH_A;
    {pl[24], pl[25]} = i[0] ? POWER_LO : POWER_HI;
    pl[22] = {7'h0, i[1]};
    pl[23] = scr_t[i];
    pl[26] = {7'h0, i[2]};
    pl[27] = cctl_t[i];
    pl[28] = 8'(i % 4);
    pl[29] = {7'h0, i[0]};
    pl[30] = {7'h0, i[1]};
    pl[31] = {7'h0, i[2]};
    pl[32] = 8'(i % 3);
    pl[33] = 8'((i + 1) % 3);
    pl[34] = 8'h01 << i;
    pl[35] = 8'h80 >> i;
    pl[36] = (i == 7) ? 8'hff : (8'h01 << (i % 6));
  endtask

  // Send the command; modulation output must hold until the final byte lands
  task automatic send_cmd(input int expect_ok);
    int p0;
    p0 = pulses;
    host_inst.send_opcode(OPCODE_MOD_CONFIG);
    for (int k = 0; k < 36; k++) host_inst.apb(1'b1, ADDR_DATA, {24'h0, pl[k]}, rd, er);
    `CHK(mod_w, last_mod)
    host_inst.apb(1'b1, ADDR_DATA, {24'h0, pl[36]}, rd, er);
    for (int n = 0; n < 10 && pulses == p0; n++) @(posedge clk);
    repeat (2) @(posedge clk);
    `CHK(pulses - p0, expect_ok)
  endtask

  // Compare applied outputs with the bytes sent
  task automatic check_cfg();
    `CHK(freq_w, {pl[0], pl[1], pl[2], pl[3]})
    `CHK(rate_w, {pl[7], pl[8], pl[9], pl[10]})
    `CHK(aux_w, {pl[11], pl[12], pl[13], pl[14]})
    `CHK(mod_w, pl[15])
    `CHK(enc_w, pl[16])
    `CHK({rsen_w, n_w, k_w}, {pl[17][0], pl[18], pl[19]})
    `CHK(t_w, 8'((pl[18] - pl[19]) >> 1))
    `CHK(dep_w, pl[21])
    `CHK({scren_w, diff_w, scrt_w}, {pl[22][0], pl[26][0], pl[23]})
    `CHK(pwr_w, {pl[24], pl[25]})
    `CHK(cctl_w, CARRIER_OFF)
    `CHK(csel_w, pl[28])
    `CHK(spec_w, pl[29][0])
    `CHK(test_w, pl[30][0])
    `CHK(term_w, pl[31][0])
    `CHK(pol_w, pl[32][1:0])
    `CHK(src_w, pl[33][1:0])
    `CHK(maj_w, pl[34])
    `CHK(min_w, pl[35])
    `CHK(com_w, pl[36] & COMMON_MASK_BITS)
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  ////////////////////////////////////////
  // Watchdog, far beyond the roughly 1500 cycles of traffic
  initial begin
    #(20 * 30000);
    miscompares++;
    conclude();
  end

  initial begin
    resetn_n = 1'b0;
    miscompares = 0;
    checks_done = 0;
    last_mod = 8'h00;
    repeat (3) @(posedge clk);
    resetn_n <= 1'b1;
    @(posedge clk);
    `CHK({cctl_w, applied_w}, 9'h0)
    $display("test reset done");
    // Unknown opcode is flagged, unmapped place refused
    host_inst.send_opcode(16'h2602);
    host_inst.apb(1'b0, ADDR_STATUS, 32'h0, rd, er);
    `CHK(rd[4], 1'b1)
    host_inst.apb(1'b0, 8'h2c, 32'h0, rd, er);
    `CHK(er, 1'b1)
    host_inst.apb(1'b1, ADDR_CTRL, 32'h2, rd, er);
    host_inst.apb(1'b0, ADDR_STATUS, 32'h0, rd, er);
    `CHK(rd[4], 1'b0)
    $display("test opcode done");
    // Legal payloads covering every listed code
    for (int i = 0; i < 8; i++) begin
      build(i);
      send_cmd(1);
      check_cfg();
      last_mod = pl[15];
    end
    $display("test apply done");
    // Illegal modulation, depth, power and carrier code reject the whole command
    for (int j = 0; j < 4; j++) begin
      build(7);
      if (j == 0) pl[15] = 8'h03;
      if (j == 1) pl[21] = 8'h05;
      if (j == 2) {pl[24], pl[25]} = 16'hfed3;
      if (j == 3) pl[27] = 8'h06;
      send_cmd(0);
      host_inst.apb(1'b0, ADDR_STATUS, 32'h0, rd, er);
      `CHK(rd[5], 1'b1)
      `CHK({dep_w, pwr_w}, {DEPTH_B, POWER_LO})
      host_inst.apb(1'b1, ADDR_CTRL, 32'h2, rd, er);
    end
    // Abort in mid-load drops the partial payload
    host_inst.send_opcode(OPCODE_MOD_CONFIG);
    host_inst.apb(1'b1, ADDR_DATA, 32'h0, rd, er);
    host_inst.apb(1'b0, ADDR_STATUS, 32'h0, rd, er);
    `CHK(rd[1:0], 2'b10)
    host_inst.apb(1'b1, ADDR_CTRL, 32'h1, rd, er);
    host_inst.apb(1'b0, ADDR_STATUS, 32'h0, rd, er);
    `CHK(rd[1:0], 2'b00)
    `CHK(mod_w, MOD_OQPSK)
    host_inst.apb(1'b0, ADDR_TX, 32'h0, rd, er);
    `CHK(rd, {POWER_LO, CARRIER_OFF, MOD_OQPSK})
    host_inst.apb(1'b0, ADDR_COUNT, 32'h0, rd, er);
    `CHK(rd, 32'h8)
    $display("test reject done");
    conclude();
  end
endmodule
